// ==== common/ccu_consts.svh ====
/*
 * Register offsets, field positions and reset values of the
 * condition and compute unit.
 * Assumes inclusion by bare name from a design file.
 */
`ifndef CCU_CONSTS_SVH
`define CCU_CONSTS_SVH

// Register byte offsets
`define OFS_CMD 8'h00
`define OFS_OPX 8'h04
`define OFS_OPY 8'h08
`define OFS_RESA 8'h0C
`define OFS_RESB 8'h10
`define OFS_ARITH_STATUS 8'h14
`define OFS_STICKY_STATUS 8'h18
`define OFS_MASK 8'h1C
`define OFS_MODE_CONTROL_PRIMARY 8'h20
`define OFS_PC 8'h24
`define OFS_CURLC 8'h28
`define OFS_NEXTLC 8'h2C
`define OFS_MRF0 8'h30
`define OFS_MRF1 8'h34
`define OFS_MRF2 8'h38
`define OFS_MRB0 8'h3C
`define OFS_MRB1 8'h40
`define OFS_MRB2 8'h44

// Command word fields
`define CMD_OP_HI 4
`define CMD_OP_LO 0
`define CMD_CC_HI 9
`define CMD_CC_LO 5
`define CMD_BG 10

// Arithmetic status bits
`define AS_AZ 0
`define AS_AV 1
`define AS_AN 2
`define AS_AC 3
`define AS_MV 4
`define AS_MN 5
`define AS_SV 6
`define AS_SZ 7
`define AS_TF 8
`define AS_FLAG_LO 19
`define AS_FLAG_HI 22
`define AS_CACC_LO 24
`define AS_CACC_HI 31

// Sticky status bits
`define SK_AOS 0
`define SK_MOS 1
`define SK_FOS 2
`define SK_FIS 3
`define SK_CB7 4
`define SK_CB15 5
`define SK_LSO 6
`define SK_LSE 7
`define SK_LSF 8
`define SK_EVENTS 32'h0000007F

// Mode control bits
`define MD_ALUSAT 0
`define MD_TRUNC 1

// Reset values
`define RST_ZERO 32'h00000000
`define RST_STICKY_STATUS 32'h00000080

`endif

// ==== common/ccu_pkg.sv ====
/*
 * Types of the condition and compute unit: operations and condition codes.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package ccu_pkg;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_ADD = 5'h01, OP_SUB = 5'h02, OP_ADDSUB = 5'h03,
        OP_ADDC = 5'h04, OP_SUBB = 5'h05, OP_FADD = 5'h06, OP_FSUB = 5'h07,
        OP_FADDSUB = 5'h08, OP_MAC = 5'h09, OP_MCLR = 5'h0A, OP_MSAT = 5'h0B,
        OP_MRND = 5'h0C, OP_BTST = 5'h0D, OP_LPUSH = 5'h0E, OP_LPOP = 5'h0F,
        OP_LDEC = 5'h10
    } op_t;

    typedef enum logic [4:0] {
        CC_EQ = 5'h00, CC_NE = 5'h01, CC_GE = 5'h02, CC_LT = 5'h03,
        CC_LE = 5'h04, CC_GT = 5'h05, CC_AC = 5'h06, CC_NAC = 5'h07,
        CC_AV = 5'h08, CC_NAV = 5'h09, CC_MV = 5'h0A, CC_NMV = 5'h0B,
        CC_MS = 5'h0C, CC_NMS = 5'h0D, CC_SV = 5'h0E, CC_NSV = 5'h0F,
        CC_SZ = 5'h10, CC_NSZ = 5'h11, CC_FL0 = 5'h12, CC_NFL0 = 5'h13,
        CC_FL1 = 5'h14, CC_NFL1 = 5'h15, CC_FL2 = 5'h16, CC_NFL2 = 5'h17,
        CC_FL3 = 5'h18, CC_NFL3 = 5'h19, CC_TF = 5'h1A, CC_NTF = 5'h1B,
        CC_LCE = 5'h1C, CC_NLCE = 5'h1D, CC_FOREVER = 5'h1E, CC_TRUE = 5'h1F
    } cond_t;

endpackage : ccu_pkg

`default_nettype wire

// ==== hw/dsp_condition_and_compute_unit.sv ====
/*
 * Condition evaluation and compute datapath behind an APB slave.
 * Assumes a single APB master on pclk; flag and buffer overflow pins
 * synchronous to pclk; pc_in driven by the sequencer.
 */
// The APB register port and the placing of the registers were decided locally.
`include "ccu_consts.svh"
`default_nettype none

module dsp_condition_and_compute_unit #(
    parameter int LOOP_DEPTH = 6,
    parameter int PC_W = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PC_W-1:0] pc_in,
    input wire logic [3:0] ext_flag,
    input wire logic [1:0] cb_overflow,
    output logic irq
);
    localparam int LSP_W = $clog2(LOOP_DEPTH + 1);

    if (LOOP_DEPTH < 1 || PC_W < 1 || PC_W > 32) begin : g_bad_param
        $error("Unsupported parameter values");
    end

    function automatic logic [33:0] alu_add(input logic [31:0] a, input logic [31:0] b,
            input logic cin, input logic sat);
        logic [32:0] s;
        logic ovf;
        s = {1'b0, a} + {1'b0, b} + {32'h0, cin};
        ovf = (a[31] == b[31]) && (s[31] != a[31]);
        if (ovf && sat) begin
            s[31:0] = a[31] ? 32'h80000000 : 32'h7FFFFFFF;
        end
        alu_add = {ovf, s};
    endfunction : alu_add

    function automatic logic [33:0] fp_add(input logic [31:0] a, input logic [31:0] b,
            input logic trunc);
        logic [31:0] x;
        logic [31:0] y;
        logic [26:0] mx;
        logic [26:0] my;
        logic [27:0] s;
        logic [9:0] e;
        logic [7:0] d;
        logic [24:0] m;
        x = a;
        y = b;
        if (b[30:0] > a[30:0]) begin
            x = b;
            y = a;
        end
        mx = (x[30:23] == 8'h00) ? 27'h0 : {1'b1, x[22:0], 3'b000};
        my = (y[30:23] == 8'h00) ? 27'h0 : {1'b1, y[22:0], 3'b000};
        d = x[30:23] - y[30:23];
        my = (d > 8'd26) ? 27'h0 : (my >> d);
        s = (x[31] == y[31]) ? ({1'b0, mx} + {1'b0, my}) : ({1'b0, mx} - {1'b0, my});
        e = {2'b00, x[30:23]};
        if (s[27]) begin
            s = s >> 1;
            e = e + 10'd1;
        end
        for (int i = 0; i < 26; i++) begin
            if (!s[26] && s != 28'h0) begin
                s = s << 1;
                e = e - 10'd1;
            end
        end
        m = {1'b0, s[26:3]};
        if (!trunc && s[2]) begin
            m = m + 25'd1;
        end
        if (m[24]) begin
            m = m >> 1;
            e = e + 10'd1;
        end
        if (x[30:23] == 8'hFF || y[30:23] == 8'hFF) begin
            fp_add = {2'b01, 32'hFFFFFFFF};
        end else if (s == 28'h0 || e[9] || e == 10'h0) begin
            fp_add = {2'b00, 32'h0};
        end else if (e >= 10'd255) begin
            fp_add = {2'b10, x[31], 8'hFF, 23'h0};
        end else begin
            fp_add = {2'b00, x[31], e[7:0], m[22:0]};
        end
    endfunction : fp_add

    function automatic logic cond_eval(input logic [4:0] cc, input logic [31:0] st,
            input logic loop_expired_cond);
        logic v;
        v = 1'b0;
        case (ccu_pkg::cond_t'(cc))
            ccu_pkg::CC_EQ, ccu_pkg::CC_NE: v = st[`AS_AZ];
            ccu_pkg::CC_GE, ccu_pkg::CC_LT: v = ~st[`AS_AN];
            ccu_pkg::CC_LE, ccu_pkg::CC_GT: v = st[`AS_AN] | st[`AS_AZ];
            ccu_pkg::CC_AC, ccu_pkg::CC_NAC: v = st[`AS_AC];
            ccu_pkg::CC_AV, ccu_pkg::CC_NAV: v = st[`AS_AV];
            ccu_pkg::CC_MV, ccu_pkg::CC_NMV: v = st[`AS_MV];
            ccu_pkg::CC_MS, ccu_pkg::CC_NMS: v = st[`AS_MN];
            ccu_pkg::CC_SV, ccu_pkg::CC_NSV: v = st[`AS_SV];
            ccu_pkg::CC_SZ, ccu_pkg::CC_NSZ: v = st[`AS_SZ];
            ccu_pkg::CC_FL0, ccu_pkg::CC_NFL0: v = st[`AS_FLAG_LO];
            ccu_pkg::CC_FL1, ccu_pkg::CC_NFL1: v = st[`AS_FLAG_LO + 1];
            ccu_pkg::CC_FL2, ccu_pkg::CC_NFL2: v = st[`AS_FLAG_LO + 2];
            ccu_pkg::CC_FL3, ccu_pkg::CC_NFL3: v = st[`AS_FLAG_LO + 3];
            ccu_pkg::CC_TF, ccu_pkg::CC_NTF: v = st[`AS_TF];
            ccu_pkg::CC_LCE, ccu_pkg::CC_NLCE: v = loop_expired_cond;
            ccu_pkg::CC_FOREVER, ccu_pkg::CC_TRUE: v = 1'b0;
            default: v = 1'b0;
        endcase
        cond_eval = v ^ cc[0];
    endfunction : cond_eval

    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic irq_q, irq_d;
    logic [31:0] opx_q, opx_d, opy_q, opy_d, resa_q, resa_d, resb_q, resb_d;
    logic [31:0] cmd_q, cmd_d, arith_status_q, arith_status_d, sticky_status_q, sticky_status_d;
    logic [31:0] mask_q, mask_d, mode_q, mode_d, nextlc_q, nextlc_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic [79:0] acc_q [2];
    logic [79:0] acc_d [2];
    logic [31:0] lstk_q [LOOP_DEPTH];
    logic [31:0] lstk_d [LOOP_DEPTH];
    logic [LSP_W-1:0] lsp_q, lsp_d;

    logic access, wr, go, sel, mapped;
    logic [31:0] curlc, rd_val;
    logic [33:0] ra, rb;
    logic [79:0] acc_n;
    logic [63:0] prod;
    logic [31:0] ev;

    assign curlc = (lsp_q == '0) ? 32'h0 : lstk_q[lsp_q - 1'b1];

    always_comb begin
        access = psel & penable & pready_q;
        wr = access & pwrite;
        pready_d = psel & ~penable;
        mapped = 1'b1;
        case (paddr)
            `OFS_CMD: rd_val = cmd_q;
            `OFS_OPX: rd_val = opx_q;
            `OFS_OPY: rd_val = opy_q;
            `OFS_RESA: rd_val = resa_q;
            `OFS_RESB: rd_val = resb_q;
            `OFS_ARITH_STATUS: rd_val = arith_status_q;
            `OFS_STICKY_STATUS: rd_val = sticky_status_q;
            `OFS_MASK: rd_val = mask_q;
            `OFS_MODE_CONTROL_PRIMARY: rd_val = mode_q;
            `OFS_PC: rd_val = 32'(pc_q);
            `OFS_CURLC: rd_val = curlc;
            `OFS_NEXTLC: rd_val = nextlc_q;
            `OFS_MRF0: rd_val = acc_q[0][31:0];
            `OFS_MRF1: rd_val = acc_q[0][63:32];
            `OFS_MRF2: rd_val = {16'h0, acc_q[0][79:64]};
            `OFS_MRB0: rd_val = acc_q[1][31:0];
            `OFS_MRB1: rd_val = acc_q[1][63:32];
            `OFS_MRB2: rd_val = {16'h0, acc_q[1][79:64]};
            default: begin
                rd_val = 32'h0;
                mapped = 1'b0;
            end
        endcase
        prdata_d = (psel & ~penable & ~pwrite) ? rd_val : prdata_q;
        pslverr_d = (psel & ~penable) ? ~mapped : pslverr_q;

        cmd_d = cmd_q;
        opx_d = opx_q;
        opy_d = opy_q;
        resa_d = resa_q;
        resb_d = resb_q;
        arith_status_d = arith_status_q;
        mask_d = mask_q;
        mode_d = mode_q;
        nextlc_d = nextlc_q;
        acc_d = acc_q;
        lstk_d = lstk_q;
        lsp_d = lsp_q;
        ev = {30'h0, cb_overflow} << `SK_CB7;
        pc_d = pc_in;
        go = 1'b0;
        sel = 1'b0;
        ra = 34'h0;
        rb = 34'h0;
        acc_n = 80'h0;
        prod = 64'h0;

        if (wr) begin
            case (paddr)
                `OFS_CMD: cmd_d = pwdata;
                `OFS_OPX: opx_d = pwdata;
                `OFS_OPY: opy_d = pwdata;
                `OFS_ARITH_STATUS: arith_status_d = pwdata;
                `OFS_MASK: mask_d = pwdata & `SK_EVENTS;
                `OFS_MODE_CONTROL_PRIMARY: mode_d = pwdata;
                `OFS_NEXTLC: nextlc_d = pwdata;
                `OFS_MRF0: acc_d[0][31:0] = pwdata;
                `OFS_MRF1: acc_d[0][63:32] = pwdata;
                `OFS_MRF2: acc_d[0][79:64] = pwdata[15:0];
                `OFS_MRB0: acc_d[1][31:0] = pwdata;
                `OFS_MRB1: acc_d[1][63:32] = pwdata;
                `OFS_MRB2: acc_d[1][79:64] = pwdata[15:0];
                default: ;
            endcase
        end

        go = wr && (paddr == `OFS_CMD) &&
             cond_eval(pwdata[`CMD_CC_HI:`CMD_CC_LO], arith_status_q, curlc == 32'h0);
        sel = pwdata[`CMD_BG];
        if (go) begin
            case (ccu_pkg::op_t'(pwdata[`CMD_OP_HI:`CMD_OP_LO]))
                ccu_pkg::OP_ADD, ccu_pkg::OP_ADDC, ccu_pkg::OP_SUB, ccu_pkg::OP_SUBB,
                ccu_pkg::OP_ADDSUB: begin
                    case (ccu_pkg::op_t'(pwdata[`CMD_OP_HI:`CMD_OP_LO]))
                        ccu_pkg::OP_ADDC: ra = alu_add(opx_q, opy_q, arith_status_q[`AS_AC],
                                                       mode_q[`MD_ALUSAT]);
                        ccu_pkg::OP_SUB: ra = alu_add(opx_q, ~opy_q, 1'b1, mode_q[`MD_ALUSAT]);
                        ccu_pkg::OP_SUBB: ra = alu_add(opx_q, ~opy_q, arith_status_q[`AS_AC],
                                                       mode_q[`MD_ALUSAT]);
                        default: ra = alu_add(opx_q, opy_q, 1'b0, mode_q[`MD_ALUSAT]);
                    endcase
                    rb = alu_add(opx_q, ~opy_q, 1'b1, mode_q[`MD_ALUSAT]);
                    resa_d = ra[31:0];
                    if (pwdata[`CMD_OP_HI:`CMD_OP_LO] == ccu_pkg::OP_ADDSUB) begin
                        resb_d = rb[31:0];
                    end else begin
                        rb = 34'h0;
                    end
                    arith_status_d[`AS_AZ] = (ra[31:0] == 32'h0);
                    arith_status_d[`AS_AN] = ra[31];
                    arith_status_d[`AS_AC] = ra[32];
                    arith_status_d[`AS_AV] = ra[33] | rb[33];
                    if (pwdata[`CMD_OP_HI:`CMD_OP_LO] == ccu_pkg::OP_SUB) begin
                        arith_status_d[`AS_CACC_HI:`AS_CACC_LO] =
                            {ra[31] ^ (ra[33] & ~mode_q[`MD_ALUSAT]),
                             arith_status_q[`AS_CACC_HI:`AS_CACC_LO + 1]};
                    end
                    ev[`SK_AOS] = ra[33] | rb[33];
                end
                ccu_pkg::OP_FADD, ccu_pkg::OP_FSUB, ccu_pkg::OP_FADDSUB: begin
                    rb = fp_add(opx_q, {~opy_q[31], opy_q[30:0]}, mode_q[`MD_TRUNC]);
                    ra = (pwdata[`CMD_OP_HI:`CMD_OP_LO] == ccu_pkg::OP_FSUB) ? rb :
                         fp_add(opx_q, opy_q, mode_q[`MD_TRUNC]);
                    resa_d = ra[31:0];
                    if (pwdata[`CMD_OP_HI:`CMD_OP_LO] == ccu_pkg::OP_FADDSUB) begin
                        resb_d = rb[31:0];
                    end else begin
                        rb = ra;
                    end
                    arith_status_d[`AS_AZ] = (ra[30:0] == 31'h0);
                    arith_status_d[`AS_AN] = ra[31];
                    arith_status_d[`AS_AC] = 1'b0;
                    arith_status_d[`AS_AV] = ra[33] | rb[33];
                    ev[`SK_FOS] = ra[33] | rb[33];
                    ev[`SK_FIS] = ra[32] | rb[32];
                end
                ccu_pkg::OP_MAC, ccu_pkg::OP_MCLR, ccu_pkg::OP_MSAT, ccu_pkg::OP_MRND: begin
                    prod = 64'($signed(opx_q)) * 64'($signed(opy_q));
                    case (ccu_pkg::op_t'(pwdata[`CMD_OP_HI:`CMD_OP_LO]))
                        ccu_pkg::OP_MAC: acc_n = acc_q[sel] + {{16{prod[63]}}, prod};
                        ccu_pkg::OP_MRND: acc_n = {acc_q[sel][79:32] +
                                                   {47'h0, acc_q[sel][31]}, 32'h0};
                        ccu_pkg::OP_MSAT: begin
                            acc_n = acc_q[sel];
                            if (acc_q[sel][79:63] != {17{acc_q[sel][79]}}) begin
                                acc_n = {{17{acc_q[sel][79]}}, {63{~acc_q[sel][79]}}};
                            end
                        end
                        default: acc_n = 80'h0;
                    endcase
                    acc_d[sel] = acc_n;
                    arith_status_d[`AS_MV] = (acc_n[79:63] != {17{acc_n[79]}});
                    arith_status_d[`AS_MN] = acc_n[79];
                    ev[`SK_MOS] = arith_status_d[`AS_MV];
                end
                ccu_pkg::OP_BTST: begin
                    arith_status_d[`AS_TF] = opx_q[opy_q[4:0]];
                    arith_status_d[`AS_SZ] = ~opx_q[opy_q[4:0]];
                    arith_status_d[`AS_SV] = 1'b0;
                end
                ccu_pkg::OP_LPUSH: begin
                    if (lsp_q == LSP_W'(LOOP_DEPTH)) begin
                        ev[`SK_LSO] = 1'b1;
                    end else begin
                        lstk_d[lsp_q] = nextlc_q;
                        lsp_d = lsp_q + 1'b1;
                    end
                end
                ccu_pkg::OP_LPOP: begin
                    if (lsp_q != '0) begin
                        lsp_d = lsp_q - 1'b1;
                    end
                end
                ccu_pkg::OP_LDEC: begin
                    if (lsp_q != '0 && curlc != 32'h0) begin
                        lstk_d[lsp_q - 1'b1] = curlc - 32'h1;
                    end
                end
                default: ;
            endcase
        end

        arith_status_d[`AS_FLAG_HI:`AS_FLAG_LO] = ext_flag;
        sticky_status_d = sticky_status_q;
        if (wr && paddr == `OFS_STICKY_STATUS) begin
            sticky_status_d = sticky_status_q & ~(pwdata & `SK_EVENTS);
        end
        sticky_status_d = sticky_status_d | (ev & `SK_EVENTS);
        sticky_status_d[`SK_LSE] = (lsp_d == '0);
        sticky_status_d[`SK_LSF] = (lsp_d == LSP_W'(LOOP_DEPTH));
        irq_d = |(sticky_status_q & mask_q & `SK_EVENTS);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= `RST_ZERO;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            irq_q <= 1'b0;
            cmd_q <= `RST_ZERO;
            opx_q <= `RST_ZERO;
            opy_q <= `RST_ZERO;
            resa_q <= `RST_ZERO;
            resb_q <= `RST_ZERO;
            arith_status_q <= `RST_ZERO;
            sticky_status_q <= `RST_STICKY_STATUS;
            mask_q <= `RST_ZERO;
            mode_q <= `RST_ZERO;
            nextlc_q <= `RST_ZERO;
            pc_q <= '0;
            acc_q[0] <= 80'h0;
            acc_q[1] <= 80'h0;
            for (int i = 0; i < LOOP_DEPTH; i++) begin
                lstk_q[i] <= `RST_ZERO;
            end
            lsp_q <= '0;
        end else begin
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            irq_q <= irq_d;
            cmd_q <= cmd_d;
            opx_q <= opx_d;
            opy_q <= opy_d;
            resa_q <= resa_d;
            resb_q <= resb_d;
            arith_status_q <= arith_status_d;
            sticky_status_q <= sticky_status_d;
            mask_q <= mask_d;
            mode_q <= mode_d;
            nextlc_q <= nextlc_d;
            pc_q <= pc_d;
            acc_q <= acc_d;
            lstk_q <= lstk_d;
            lsp_q <= lsp_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

endmodule : dsp_condition_and_compute_unit

`default_nettype wire

// ==== test/ccu_asserts.sv ====
/* Port checker of the compute unit.
   Assumes pclk and active-low async presetn of the top module. */
`include "ccu_consts.svh"
`default_nettype none
module ccu_asserts #(
    parameter int PC_W = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [PC_W-1:0] pc_in,
    input wire logic [3:0] ext_flag,
    input wire logic [1:0] cb_overflow,
    input wire logic irq
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_rd(a);
        psel && !penable && !pwrite && paddr == a;
    endsequence
    sequence s_cb7;
        cb_overflow[0] ##1 s_rd(`OFS_STICKY_STATUS);
    endsequence
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_once: assert property (pready |=> !pready)
        else $error("ready held");
    a_bad_addr: assert property (psel && !penable && paddr > 8'h44 |=> pslverr)
        else $error("no error on unmapped address");
    a_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
        else $error("error read not zero");
    a_pc_shown: assert property (
        s_rd(`OFS_PC) ##0 $stable(pc_in) |=> prdata[PC_W-1:0] == $past(pc_in))
        else $error("pc read wrong");
    a_flags_shown: assert property (
        s_rd(`OFS_ARITH_STATUS) ##0 $stable(ext_flag) |=> prdata[22:19] == $past(ext_flag))
        else $error("flag field wrong");
    a_cb_sticky: assert property (s_cb7 |=> prdata[`SK_CB7])
        else $error("buffer overflow not latched");
    a_irq_cause: assert property (
        $rose(irq) |-> $past(cb_overflow != 2'h0 || (psel && penable && pwrite), 2))
        else $error("irq rose without event");
endmodule : ccu_asserts
bind dsp_condition_and_compute_unit ccu_asserts #(.PC_W(PC_W)) u_ccu_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pc_in(pc_in), .ext_flag(ext_flag), .cb_overflow(cb_overflow), .irq(irq)
);
`default_nettype wire

// ==== test/seq_model.sv ====
/* Sequencer stand-in: program counter, flag pins, overflow pulses.
   Assumes cmd_done marks each command word written, whether its condition passes or not. */
`default_nettype none
module seq_model #(
    parameter int PC_W = 24
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cmd_done,
    input wire logic [1:0] cb_req,
    output logic [PC_W-1:0] pc_in,
    output logic [3:0] ext_flag,
    output logic [1:0] cb_overflow
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [PC_W-1:0] pc_d;
    always_comb begin
        pc_d = pc_in + PC_W'(cmd_done);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_in <= '0;
            cb_overflow <= 2'h0;
        end else begin
            pc_in <= pc_d;
            cb_overflow <= cb_req;
        end
    end
    assign ext_flag = 4'h5;
endmodule : seq_model
`default_nettype wire

// ==== test/testbench.sv ====
/* Self-checking bench of the compute unit over APB.
   Assumes the checker is bound to the design. */
`include "ccu_consts.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] TBL = 32'h9A66AA55;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [23:0] pc_in;
    logic [3:0] ext_flag;
    logic [1:0] cb_overflow, cb_req;
    int fail_count = 0;
    int n_checks = 0;
    int n_cmds = 0;
    wire logic cmd_done = psel && penable && pready && pwrite && paddr == `OFS_CMD;
    dsp_condition_and_compute_unit #(.LOOP_DEPTH(6), .PC_W(24)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pc_in(pc_in), .ext_flag(ext_flag),
        .cb_overflow(cb_overflow), .irq(irq)
    );
    seq_model #(.PC_W(24)) u_seq (
        .pclk(pclk), .presetn(presetn), .cmd_done(cmd_done), .cb_req(cb_req),
        .pc_in(pc_in), .ext_flag(ext_flag), .cb_overflow(cb_overflow)
    );
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task automatic check(input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            fail_count++;
            $display("wrong value at %0t: %h, expected %h", $time, s, x);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(q, x);
    endtask : rc
    task automatic opnd(input logic [31:0] x, input logic [31:0] y);
        wr(`OFS_OPX, x);
        wr(`OFS_OPY, y);
    endtask : opnd
    task automatic cmd(input logic [4:0] op, input logic [4:0] cc, input logic bg);
        n_cmds++;
        wr(`OFS_CMD, {21'h0, bg, cc, op});
    endtask : cmd
    task automatic cpair(input logic [4:0] cc, input logic t);
        cmd(ccu_pkg::OP_SUB, ccu_pkg::CC_TRUE, 1'b0);
        cmd(ccu_pkg::OP_ADD, cc, 1'b0);
        rc(`OFS_RESA, t ? 32'h4 : 32'h0);
    endtask : cpair
    task automatic pulse(input logic [1:0] b);
        @(posedge pclk);
        cb_req <= b;
        @(posedge pclk);
        cb_req <= 2'h0;
    endtask : pulse
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        wrap_up();
    end
    initial begin
        {presetn, psel, penable, pwrite} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        cb_req = 2'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rc(`OFS_STICKY_STATUS, 32'h80);
        rc(`OFS_MODE_CONTROL_PRIMARY, 32'h0);
        apb(1'b0, 8'h80, 32'h0);
        check({31'h0, e}, 32'h1);
        $display("reset test done");
        opnd(32'hFFFFFFFF, 32'h1);
        cmd(ccu_pkg::OP_ADD, ccu_pkg::CC_TRUE, 1'b0);
        opnd(32'h5, 32'h3);
        cmd(ccu_pkg::OP_ADDC, ccu_pkg::CC_TRUE, 1'b0);
        rc(`OFS_RESA, 32'h9);
        cmd(ccu_pkg::OP_SUBB, ccu_pkg::CC_TRUE, 1'b0);
        rc(`OFS_RESA, 32'h1);
        opnd(32'h7, 32'h2);
        cmd(ccu_pkg::OP_ADDSUB, ccu_pkg::CC_TRUE, 1'b0);
        rc(`OFS_RESA, 32'h9);
        rc(`OFS_RESB, 32'h5);
        $display("carry test done");
        wr(`OFS_MODE_CONTROL_PRIMARY, 32'h1);
        opnd(32'h7FFFFFFF, 32'h1);
        cmd(ccu_pkg::OP_ADD, ccu_pkg::CC_TRUE, 1'b0);
        rc(`OFS_RESA, 32'h7FFFFFFF);
        rc(`OFS_STICKY_STATUS, 32'h81);
        wr(`OFS_STICKY_STATUS, 32'h1);
        rc(`OFS_STICKY_STATUS, 32'h80);
        wr(`OFS_MODE_CONTROL_PRIMARY, 32'h0);
        cmd(ccu_pkg::OP_ADD, ccu_pkg::CC_TRUE, 1'b0);
        rc(`OFS_RESA, 32'h80000000);
        wr(`OFS_STICKY_STATUS, 32'h1);
        opnd(32'h3F800000, 32'h3F000000);
        cmd(ccu_pkg::OP_FADDSUB, ccu_pkg::CC_TRUE, 1'b0);
        rc(`OFS_RESA, 32'h3FC00000);
        rc(`OFS_RESB, 32'h3F000000);
        wr(`OFS_MODE_CONTROL_PRIMARY, 32'h2);
        opnd(32'h3F800000, 32'h33800000);
        cmd(ccu_pkg::OP_FADD, ccu_pkg::CC_TRUE, 1'b0);
        rc(`OFS_RESA, 32'h3F800000);
        wr(`OFS_MODE_CONTROL_PRIMARY, 32'h0);
        cmd(ccu_pkg::OP_FADD, ccu_pkg::CC_TRUE, 1'b0);
        rc(`OFS_RESA, 32'h3F800001);
        $display("saturation test done");
        wr(`OFS_MASK, 32'h10);
        pulse(2'h1);
        rc(`OFS_STICKY_STATUS, 32'h90);
        check({31'h0, irq}, 32'h1);
        pulse(2'h2);
        rc(`OFS_STICKY_STATUS, 32'hB0);
        wr(`OFS_STICKY_STATUS, 32'h10);
        rc(`OFS_STICKY_STATUS, 32'hA0);
        check({31'h0, irq}, 32'h0);
        wr(`OFS_MASK, 32'h20);
        rc(`OFS_MASK, 32'h20);
        check({31'h0, irq}, 32'h1);
        wr(`OFS_STICKY_STATUS, 32'h20);
        rc(`OFS_STICKY_STATUS, 32'h80);
        check({31'h0, irq}, 32'h0);
        $display("interrupt test done");
        wr(`OFS_NEXTLC, 32'h2);
        cmd(ccu_pkg::OP_LPUSH, ccu_pkg::CC_TRUE, 1'b0);
        wr(`OFS_NEXTLC, 32'h7);
        wr(`OFS_CURLC, 32'h5);
        rc(`OFS_CURLC, 32'h2);
        rc(`OFS_NEXTLC, 32'h7);
        opnd(32'h2, 32'h2);
        cmd(ccu_pkg::OP_LDEC, ccu_pkg::CC_TRUE, 1'b0);
        cpair(ccu_pkg::CC_NLCE, 1'b1);
        cpair(ccu_pkg::CC_LCE, 1'b0);
        cmd(ccu_pkg::OP_LDEC, ccu_pkg::CC_TRUE, 1'b0);
        for (int c = 0; c < 32; c++) begin
            cpair(5'(c), TBL[c]);
        end
        apb(1'b0, `OFS_ARITH_STATUS, 32'h0);
        check({28'h0, q[22:19]}, 32'h5);
        opnd(32'h2, 32'h1);
        cmd(ccu_pkg::OP_BTST, ccu_pkg::CC_TRUE, 1'b0);
        opnd(32'h2, 32'h2);
        cpair(ccu_pkg::CC_TF, 1'b1);
        cpair(ccu_pkg::CC_NSZ, 1'b1);
        $display("condition test done");
        opnd(32'h3, 32'h4);
        cmd(ccu_pkg::OP_MAC, ccu_pkg::CC_TRUE, 1'b0);
        opnd(32'h2, 32'h5);
        cmd(ccu_pkg::OP_MAC, ccu_pkg::CC_TRUE, 1'b1);
        rc(`OFS_MRF0, 32'hC);
        cmd(ccu_pkg::OP_MCLR, ccu_pkg::CC_TRUE, 1'b0);
        rc(`OFS_MRF0, 32'h0);
        rc(`OFS_MRB0, 32'hA);
        opnd(32'h10000, 32'h10000);
        cmd(ccu_pkg::OP_MAC, ccu_pkg::CC_TRUE, 1'b0);
        rc(`OFS_MRF1, 32'h1);
        wr(`OFS_MRF0, 32'h80000000);
        cmd(ccu_pkg::OP_MRND, ccu_pkg::CC_TRUE, 1'b0);
        rc(`OFS_MRF1, 32'h2);
        wr(`OFS_MRF2, 32'h1);
        cmd(ccu_pkg::OP_MSAT, ccu_pkg::CC_TRUE, 1'b0);
        rc(`OFS_MRF1, 32'h7FFFFFFF);
        wr(`OFS_PC, 32'hFFFFFFFF);
        rc(`OFS_PC, 32'(n_cmds));
        $display("accumulator test done");
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
